/* File: hdl/vgc_pkg.sv */
// Constants for the video gamut checker
package vgc_pkg;
   typedef enum logic [2:0] {
      MODE_BCAST = 3'b001,
      MODE_NARROW = 3'b010,
      MODE_CUSTOM = 3'b100
   } vgc_mode_type;

   // Component order inside every per-component vector
   localparam int C_Y = 0;
   localparam int C_CB = 1;
   localparam int C_CR = 2;
   localparam int C_G = 3;
   localparam int C_B = 4;
   localparam int C_R = 5;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SEL = 8'h04;
   localparam logic [7:0] OFS_THR = 8'h08;
   localparam logic [7:0] OFS_TOTAL = 8'h0c;
   localparam logic [7:0] OFS_LIM0 = 8'h10;
   localparam logic [7:0] OFS_PCT = 8'h28;
   localparam logic [7:0] OFS_PIXCNT = 8'h2c;
   localparam logic [7:0] OFS_FRMCNT = 8'h30;
   localparam logic [7:0] OFS_TIME = 8'h34;
   localparam logic [7:0] OFS_MINMAX0 = 8'h40;

   // CTRL field positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_CLR = 1;
   localparam int CTRL_MODE = 4;
   localparam int CTRL_ZEB_EN = 8;
   localparam int CTRL_ZEB_TYPE = 9;
   localparam int CTRL_MONO = 11;
   // SEL field positions
   localparam int SEL_ERR = 0;
   localparam int SEL_ZEB = 8;
   localparam int SEL_FILT = 16;
   // Limit register: min low, max high
   localparam int LIM_MAX = 16;

   // Preset limits, 10-bit codes
   localparam logic [9:0] BC_RGBY_MIN = 10'h014;
   localparam logic [9:0] BC_RGBY_MAX = 10'h3d8;
   localparam logic [9:0] NR_RGBY_MIN = 10'h040;
   localparam logic [9:0] NR_RGBY_MAX = 10'h3ac;
   localparam logic [9:0] CHROMA_MIN = 10'h040;
   localparam logic [9:0] CHROMA_MAX = 10'h3c0;

   // Preset selections
   localparam logic [5:0] SEL_LUMA_RGB = 6'h39;
   localparam logic [5:0] SEL_ALL = 6'h3f;
   localparam logic BC_FILT_RST = 1'b1;
   localparam logic NR_FILT_RST = 1'b0;

   // Threshold in hundredths of a percent; reset value is one percent
   localparam logic [15:0] THR_RST = 16'h0064;
   localparam logic [39:0] PCT_SCALE = 40'h0000002710;
   localparam logic [23:0] TOTAL_RST = 24'h1fa400;
   localparam logic [5:0] DIV_STEPS = 6'h28;

   // Overlay colours
   localparam logic [9:0] COL_HI = 10'h3ac;
   localparam logic [9:0] COL_LO = 10'h040;
   localparam int HATCH_BIT = 2;
endpackage

/* File: hdl/vgc_checker.sv */
// Video gamut checker with APB registers, frame statistics and zebra overlay
// Operation
// R01: broadcast mode flags luma/RGB outside -5..105 percent
// R02: broadcast limits 20-984 luma/RGB, 64-960 chroma
// R03: narrow limits 64-940 luma/RGB, all six monitored
// R04: optional seven-tap smoothing on Y, R, G, B
// R05: smoothing stays within one line
// R06: narrow mode smoothing off by default
// R07: selected component errors merge into pixel error
// R08: per-frame error percentage of active pixel total
// R09: frame in error above threshold, default one percent
// R10: count erroneous frames or fields since reset
// R11: clear command zeroes counters and time
// R12: monitor runs every frame until disabled
// R13: error select gates component into counts
// R14: zebra select gates component into overlay
// R15: overlay defaults follow mode component set
// R16: overlay enable and four colour pairs
// R17: monochrome picture option under overlay
// R18: editing a preset switches to custom mode
// R19: custom kept across presets, preset edit replaces
// R20: threshold written in hundredths of a percent
// R21: capture per-frame unfiltered min and max
// R22: source gives one qualified pixel per clock
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
module vgc_checker
   import vgc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pixActive,
   input wire logic pixSof,
   input wire logic [9:0] pixY,
   input wire logic [9:0] pixCb,
   input wire logic [9:0] pixCr,
   input wire logic [9:0] pixG,
   input wire logic [9:0] pixB,
   input wire logic [9:0] pixR,
   output logic pixErr,
   output logic zebMark,
   output logic frameErr,
   output logic outValid,
   output logic [9:0] outR,
   output logic [9:0] outG,
   output logic [9:0] outB
);
   typedef struct packed {
      vgc_mode_type mode;
      logic en;
      logic mono;
      logic zebEn;
      logic [1:0] zebType;
      logic filt;
      logic [5:0] errSel;
      logic [5:0] zebSel;
      logic [5:0][19:0] lim;
      logic [15:0] thr;
      logic [23:0] total;
      logic [3:0][5:0][9:0] hist;
      logic lineOn;
      logic [11:0] xPos;
      logic [11:0] yPos;
      logic seen;
      logic [23:0] frmPix;
      logic [31:0] pixCnt;
      logic [31:0] frmCnt;
      logic [31:0] timeCnt;
      logic [15:0] pct;
      logic [5:0][9:0] runMin;
      logic [5:0][9:0] runMax;
      logic [5:0][9:0] repMin;
      logic [5:0][9:0] repMax;
      logic [39:0] dvd;
      logic [23:0] rem;
      logic [5:0] divCnt;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic pixErr;
      logic zebMark;
      logic frameErr;
      logic outValid;
      logic [9:0] outR;
      logic [9:0] outG;
      logic [9:0] outB;
   } vgc_state_type;

   vgc_state_type s_q;
   vgc_state_type s_d;

   // Preset limit pair {max, min} for one component
   function automatic logic [19:0] presetLim(vgc_mode_type m, int c);
      if (c == C_CB || c == C_CR)
         return {CHROMA_MAX, CHROMA_MIN}; // [R02] [R03]
      else if (m == MODE_NARROW)
         return {NR_RGBY_MAX, NR_RGBY_MIN}; // [R03]
      else
         return {BC_RGBY_MAX, BC_RGBY_MIN}; // [R01] [R02]
   endfunction

   function automatic logic [5:0] presetSel(vgc_mode_type m);
      return (m == MODE_NARROW) ? SEL_ALL : SEL_LUMA_RGB; // [R03] [R15]
   endfunction

   // Weights 1,2,3,3,3,3,1 over sixteenths, newest sample first
   function automatic logic [9:0] smooth(logic [9:0] x, logic [5:0][9:0] h);
      logic [13:0] sum;
      sum = 14'(x) + 14'({h[0], 1'b0}) + 14'(h[5]);
      sum = sum + 14'(3) * (14'(h[1]) + 14'(h[2]) + 14'(h[3]) + 14'(h[4])); // [R04]
      return sum[13:4];
   endfunction

   // Filtered channels map onto Y, G, B, R
   function automatic int filtComp(int k);
      return (k == 0) ? C_Y : (k + 2);
   endfunction

   logic [5:0][9:0] raw;
   logic [5:0][9:0] val;
   logic [5:0][19:0] eLim;
   logic [5:0] eErr;
   logic [5:0] eZeb;
   logic [5:0] oor;
   logic eFilt;
   logic [3:0][5:0][9:0] hUse;
   logic errNow;
   logic zebNow;
   logic apbWr;
   logic cfgWr;
   logic [2:0] limIdx;
   logic [2:0] mmIdx;
   logic [24:0] trial;
   logic [39:0] errScaled;
   logic [39:0] thrScaled;
   logic [9:0] baseR;
   logic [9:0] baseG;
   logic [9:0] baseB;
   logic hatch;
   logic [29:0] hiCol;

   always_comb begin
      s_d = s_q;
      raw = {pixR, pixB, pixG, pixCr, pixCb, pixY};
      // Preset modes read constants so custom storage survives untouched
      if (s_q.mode == MODE_CUSTOM) begin
         eFilt = s_q.filt;
         eErr = s_q.errSel;
         eZeb = s_q.zebSel;
         eLim = s_q.lim;
      end else begin
         eFilt = (s_q.mode == MODE_NARROW) ? NR_FILT_RST : BC_FILT_RST; // [R06]
         eErr = presetSel(s_q.mode);
         eZeb = presetSel(s_q.mode); // [R15]
         for (int c = 0; c < 6; c++)
            eLim[c] = presetLim(s_q.mode, c);
      end

      // A line's first sample seeds the history, so no tap reaches the previous line
      val = raw;
      for (int k = 0; k < 4; k++) begin
         hUse[k] = s_q.lineOn ? s_q.hist[k] : {6{raw[filtComp(k)]}}; // [R05]
         if (eFilt)
            val[filtComp(k)] = smooth(raw[filtComp(k)], hUse[k]); // [R04]
      end
      for (int c = 0; c < 6; c++)
         oor[c] = (val[c] < eLim[c][9:0]) || (val[c] > eLim[c][19:10+LIM_MAX-16]); // [R01]
      errNow = s_q.en && pixActive && |(oor & eErr); // [R07] [R13]
      zebNow = s_q.en && pixActive && |(oor & eZeb); // [R14]

      if (pixActive) begin
         for (int k = 0; k < 4; k++)
            s_d.hist[k] = {hUse[k][4:0], raw[filtComp(k)]};
         s_d.xPos = s_q.xPos + 12'h001;
      end else begin
         s_d.xPos = 12'h000;
      end
      s_d.lineOn = pixActive;
      if (pixSof)
         s_d.yPos = 12'h000;
      else if (s_q.lineOn && !pixActive)
         s_d.yPos = s_q.yPos + 12'h001;

      // Frame statistics
      errScaled = 40'(s_q.frmPix) * PCT_SCALE; // [R08]
      thrScaled = 40'(s_q.thr) * 40'(s_q.total); // [R20]
      s_d.frameErr = 1'b0;
      if (s_q.en) begin
         s_d.timeCnt = s_q.timeCnt + 32'h00000001;
         if (errNow)
            s_d.pixCnt = s_q.pixCnt + 32'h00000001;
         if (pixSof) begin
            if (s_q.seen) begin
               if (errScaled > thrScaled) begin // [R09]
                  s_d.frameErr = 1'b1;
                  s_d.frmCnt = s_q.frmCnt + 32'h00000001; // [R10]
               end
               s_d.repMin = s_q.runMin; // [R21]
               s_d.repMax = s_q.runMax;
               if (s_q.total == 24'h000000) begin
                  s_d.pct = 16'h0000;
                  s_d.divCnt = 6'h00;
               end else begin
                  s_d.dvd = errScaled; // [R08]
                  s_d.rem = 24'h000000;
                  s_d.divCnt = DIV_STEPS;
               end
            end
            s_d.seen = 1'b1; // [R12]
            s_d.frmPix = {23'h000000, errNow};
            for (int c = 0; c < 6; c++) begin
               s_d.runMin[c] = pixActive ? raw[c] : 10'h3ff;
               s_d.runMax[c] = pixActive ? raw[c] : 10'h000;
            end
         end else begin
            if (errNow)
               s_d.frmPix = s_q.frmPix + 24'h000001;
            if (pixActive) begin
               for (int c = 0; c < 6; c++) begin
                  if (raw[c] < s_q.runMin[c])
                     s_d.runMin[c] = raw[c]; // [R21]
                  if (raw[c] > s_q.runMax[c])
                     s_d.runMax[c] = raw[c];
               end
            end
         end
      end else begin
         s_d.seen = 1'b0;
      end

      // Serial restoring divide keeps the percentage off the pixel path
      trial = {s_q.rem, s_q.dvd[39]};
      if (s_q.divCnt != 6'h00 && !(s_q.en && pixSof && s_q.seen)) begin
         if (trial >= {1'b0, s_q.total}) begin
            s_d.rem = 24'(trial - {1'b0, s_q.total});
            s_d.dvd = {s_q.dvd[38:0], 1'b1};
         end else begin
            s_d.rem = trial[23:0];
            s_d.dvd = {s_q.dvd[38:0], 1'b0};
         end
         s_d.divCnt = s_q.divCnt - 6'h01;
         if (s_q.divCnt == 6'h01)
            s_d.pct = (|s_d.dvd[39:16]) ? 16'hffff : s_d.dvd[15:0];
      end

      // APB: one access cycle, data prepared during setup
      apbWr = psel && penable && pwrite && s_q.pready;
      limIdx = 3'((paddr - OFS_LIM0) >> 2);
      mmIdx = 3'((paddr - OFS_MINMAX0) >> 2);
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel && !penable) begin
         s_d.pready = 1'b1;
         s_d.prdata = 32'h00000000;
         case (paddr)
            OFS_CTRL: begin
               s_d.prdata[CTRL_EN] = s_q.en;
               s_d.prdata[CTRL_MODE +: 3] = s_q.mode;
               s_d.prdata[CTRL_ZEB_EN] = s_q.zebEn;
               s_d.prdata[CTRL_ZEB_TYPE +: 2] = s_q.zebType;
               s_d.prdata[CTRL_MONO] = s_q.mono;
            end
            OFS_SEL: begin
               s_d.prdata[SEL_ERR +: 6] = eErr;
               s_d.prdata[SEL_ZEB +: 6] = eZeb;
               s_d.prdata[SEL_FILT] = eFilt;
            end
            OFS_THR: s_d.prdata = {16'h0000, s_q.thr};
            OFS_TOTAL: s_d.prdata = {8'h00, s_q.total};
            OFS_PCT: s_d.prdata = {16'h0000, s_q.pct};
            OFS_PIXCNT: s_d.prdata = s_q.pixCnt;
            OFS_FRMCNT: s_d.prdata = s_q.frmCnt;
            OFS_TIME: s_d.prdata = s_q.timeCnt;
            default: begin
               if (paddr[1:0] == 2'b00 && paddr >= OFS_LIM0 && limIdx < 3'h6
                   && paddr < OFS_PCT) begin
                  s_d.prdata = {6'h00, eLim[limIdx][19:10], 6'h00, eLim[limIdx][9:0]};
               end else if (paddr[1:0] == 2'b00 && paddr >= OFS_MINMAX0 && mmIdx < 3'h6
                            && paddr < OFS_MINMAX0 + 8'h18) begin
                  s_d.prdata = {6'h00, s_q.repMax[mmIdx], 6'h00, s_q.repMin[mmIdx]};
               end else begin
                  s_d.pslverr = 1'b1;
               end
            end
         endcase
      end

      cfgWr = apbWr && !s_q.pslverr && (paddr == OFS_SEL
              || (paddr >= OFS_LIM0 && paddr < OFS_PCT));
      if (cfgWr && s_q.mode != MODE_CUSTOM) begin
         // An edit from a preset starts a fresh custom set from that preset
         s_d.mode = MODE_CUSTOM; // [R18] [R19]
         s_d.filt = eFilt;
         s_d.errSel = eErr;
         s_d.zebSel = eZeb;
         s_d.lim = eLim;
      end
      if (apbWr && !s_q.pslverr) begin
         if (paddr == OFS_CTRL) begin
            s_d.en = pwdata[CTRL_EN]; // [R12]
            s_d.zebEn = pwdata[CTRL_ZEB_EN]; // [R16]
            s_d.zebType = pwdata[CTRL_ZEB_TYPE +: 2];
            s_d.mono = pwdata[CTRL_MONO]; // [R17]
            // Only a one-hot mode code is accepted
            if (pwdata[CTRL_MODE +: 3] == MODE_BCAST || pwdata[CTRL_MODE +: 3] == MODE_NARROW
                || pwdata[CTRL_MODE +: 3] == MODE_CUSTOM)
               s_d.mode = vgc_mode_type'(pwdata[CTRL_MODE +: 3]); // [R19]
            if (pwdata[CTRL_CLR]) begin
               s_d.pct = 16'h0000; // [R11]
               s_d.pixCnt = 32'h00000000;
               s_d.frmCnt = 32'h00000000;
               s_d.timeCnt = 32'h00000000;
               s_d.frmPix = 24'h000000;
               s_d.divCnt = 6'h00;
            end
         end else if (paddr == OFS_SEL) begin
            s_d.errSel = pwdata[SEL_ERR +: 6]; // [R13]
            s_d.zebSel = pwdata[SEL_ZEB +: 6]; // [R14]
            s_d.filt = pwdata[SEL_FILT];
         end else if (paddr == OFS_THR) begin
            s_d.thr = pwdata[15:0]; // [R20]
         end else if (paddr == OFS_TOTAL) begin
            s_d.total = pwdata[23:0];
         end else if (paddr >= OFS_LIM0 && paddr < OFS_PCT) begin
            s_d.lim[limIdx] = {pwdata[LIM_MAX +: 10], pwdata[9:0]};
         end
      end

      // Overlay: 4x4 checker pattern over the picture or its monochrome version
      baseR = s_q.mono ? pixY : pixR; // [R17]
      baseG = s_q.mono ? pixY : pixG;
      baseB = s_q.mono ? pixY : pixB;
      hatch = s_d.xPos[HATCH_BIT] ^ s_q.yPos[HATCH_BIT];
      hiCol = s_q.zebType[1] ? {COL_HI, COL_LO, COL_LO} : {COL_HI, COL_HI, COL_HI};
      s_d.outValid = pixActive;
      s_d.pixErr = errNow;
      s_d.zebMark = zebNow && s_q.zebEn;
      if (zebNow && s_q.zebEn) begin // [R14] [R16]
         if (hatch)
            {s_d.outR, s_d.outG, s_d.outB} = hiCol;
         else if (s_q.zebType[0])
            {s_d.outR, s_d.outG, s_d.outB} = {baseR >> 2, baseG >> 2, baseB >> 2};
         else
            {s_d.outR, s_d.outG, s_d.outB} = {COL_LO, COL_LO, COL_LO};
      end else begin
         {s_d.outR, s_d.outG, s_d.outB} = {baseR, baseG, baseB};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.mode <= MODE_BCAST;
         s_q.filt <= BC_FILT_RST;
         s_q.errSel <= SEL_LUMA_RGB;
         s_q.zebSel <= SEL_LUMA_RGB;
         for (int c = 0; c < 6; c++)
            s_q.lim[c] <= presetLim(MODE_BCAST, c);
         s_q.thr <= THR_RST; // [R09]
         s_q.total <= TOTAL_RST;
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign pixErr = s_q.pixErr;
   assign zebMark = s_q.zebMark;
   assign frameErr = s_q.frameErr;
   assign outValid = s_q.outValid;
   assign outR = s_q.outR;
   assign outG = s_q.outG;
   assign outB = s_q.outB;
endmodule // vgc_checker

/* File: tb/vgc_checker_assertions.sv */
// Port-level assertions for the video gamut checker
`timescale 1ns/10ps
module vgc_checker_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic pixActive,
   input wire logic pixSof,
   input wire logic pixErr,
   input wire logic zebMark,
   input wire logic frameErr,
   input wire logic outValid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   // A frozen block answers nothing, so its cycles are not judged
   default disable iff (!rst_n || !clkEn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_ready_src;
      pready |-> s_access and $past(psel && !penable);
   endproperty
   property p_slverr;
      pslverr |-> pready;
   endproperty
   property p_valid;
      outValid == $past(pixActive);
   endproperty
   property p_err_src;
      pixErr |-> $past(pixActive);
   endproperty
   property p_zeb_src;
      zebMark |-> $past(pixActive);
   endproperty
   property p_frm_src;
      frameErr |-> $past(pixSof);
   endproperty
   property p_frm_pulse;
      frameErr |=> !frameErr;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   a_ready_src: assert property (p_ready_src) else $error("ready outside access");
   a_slverr: assert property (p_slverr) else $error("slave error without ready");
   a_valid: assert property (p_valid) else $error("output valid not one cycle late");
   a_err_src: assert property (p_err_src) else $error("pixel error without pixel");
   a_zeb_src: assert property (p_zeb_src) else $error("overlay mark without pixel");
   a_frm_src: assert property (p_frm_src) else $error("frame error not after start");
   a_frm_pulse: assert property (p_frm_pulse) else $error("frame error too long");
endmodule // vgc_checker_sva

bind vgc_checker vgc_checker_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .pixActive(pixActive),
   .pixSof(pixSof), .pixErr(pixErr), .zebMark(zebMark), .frameErr(frameErr),
   .outValid(outValid), .clkEn(clkEn));

/* File: tb/vgc_pix_source.sv */
// Upstream pixel source: frames of two lines of eight pixels
`timescale 1ns/10ps
module vgc_pix_source (
   input wire logic sys_clk,
   input wire logic start,
   input wire logic [59:0] base,
   input wire logic [9:0] spikeY,
   output logic busy,
   output logic pixActive,
   output logic pixSof,
   output logic [9:0] pixY,
   output logic [9:0] pixCb,
   output logic [9:0] pixCr,
   output logic [9:0] pixG,
   output logic [9:0] pixB,
   output logic [9:0] pixR
);
   int pos = 0;
   logic [59:0] cur = '0;
   assign {pixR, pixB, pixG, pixCr, pixCb, pixY} = cur;
   initial begin
      busy = 1'h0;
      pixActive = 1'h0;
      pixSof = 1'h0;
   end
   // Blanking shows a toggling bus so stale data is never mistaken for a pixel
   always @(posedge sys_clk) begin
      if (!busy) begin
         busy <= start;
         pos <= 0;
         pixActive <= 1'h0;
         pixSof <= 1'h0;
         cur <= ~cur;
      end else begin
         pixActive <= (pos % 10) < 8;
         pixSof <= pos == 0;
         if ((pos % 10) >= 8)
            cur <= ~cur;
         else if ((pos % 10) == 3)
            cur <= {base[59:10], spikeY};
         else
            cur <= base;
         pos <= pos + 1;
         busy <= pos < 19;
      end
   end
endmodule // vgc_pix_source

/* File: tb/test_video_gamut_checker.sv */
// Self-checking bench for the video gamut checker
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_video_gamut_checker;
   import vgc_pkg::*;
   logic sys_clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, start = '0, clkEn = '1;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, err, pixActive, pixSof, pixErr, zebMark, frameErr, outValid, busy;
   logic [9:0] pixY, pixCb, pixCr, pixG, pixB, pixR, outR, outG, outB, spikeY = '0;
   logic [59:0] base = '0;
   logic [1:0] zType = '0;
   int error_cnt = 0, comparisons = 0, nErr, nZeb, nFrm, nBad, nMono, nHatch;
   localparam logic [59:0] MID = {6{10'h1f4}};
   vgc_checker dut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pixActive(pixActive), .pixSof(pixSof),
      .pixY(pixY), .pixCb(pixCb), .pixCr(pixCr), .pixG(pixG), .pixB(pixB), .pixR(pixR),
      .pixErr(pixErr), .zebMark(zebMark), .frameErr(frameErr), .outValid(outValid),
      .outR(outR), .outG(outG), .outB(outB));
   vgc_pix_source src (.sys_clk(sys_clk), .start(start), .base(base), .spikeY(spikeY),
      .busy(busy), .pixActive(pixActive), .pixSof(pixSof), .pixY(pixY), .pixCb(pixCb),
      .pixCr(pixCr), .pixG(pixG), .pixB(pixB), .pixR(pixR));
   initial forever #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (pixErr === 1'h1) nErr++;
      if (frameErr === 1'h1) nFrm++;
      if (zebMark === 1'h1) nZeb++;
      if (zebMark === 1'h1 && !(outR === COL_HI && outG === (zType[1] ? COL_LO : COL_HI)
          || outR === outG && outG === (zType[0] ? (MID[9:0] >> 2) : COL_LO))) nBad++;
      if (zebMark === 1'h1 && outR === COL_HI) nHatch++;
      if (outValid === 1'h1 && (outR !== outG || outG !== outB)) nMono++;
      // Counters above would silently skip an unknown output
      if (rst_n === 1'h1)
         `CHK(^{pixErr, zebMark, frameErr, outValid, outR, outG, outB} === 1'bx, 1'b0)
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n >= 50) error_cnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rdv(input logic [7:0] a);
      apb(1'h0, a, '0);
   endtask
   function automatic logic [59:0] with1(input int c, input logic [9:0] v);
      logic [59:0] p;
      p = MID;
      p[c*10 +: 10] = v;
      return p;
   endfunction
   // Spike replaces the luma of the fourth pixel of every line
   task automatic frame(input logic [59:0] b, input logic [9:0] s);
      int n = 0;
      base <= b;
      spikeY <= s;
      start <= 1'h1;
      @(posedge sys_clk);
      start <= 1'h0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (busy === 1'h1 && n < 50);
      if (n >= 50) error_cnt++;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic t_reset;
      rdv(OFS_CTRL); `CHK(rd, 32'h10)
      rdv(OFS_SEL); `CHK(rd, 32'h13939)
      rdv(OFS_THR); `CHK(rd, 32'h64)
      rdv(OFS_LIM0); `CHK(rd, 32'h03d80014)
      rdv(OFS_LIM0 + 8'h04); `CHK(rd, 32'h03c00040)
      rdv(8'hfc); `CHK(err, 1'h1)
   endtask
   task automatic t_bcast;
      int c[6] = '{C_Y, C_Y, C_Y, C_Y, C_CB, C_G};
      logic [9:0] v[6] = '{BC_RGBY_MIN - 10'h1, BC_RGBY_MIN, BC_RGBY_MAX,
         BC_RGBY_MAX + 10'h1, 10'h00a, 10'h3e8};
      int e[6] = '{16, 0, 0, 16, 0, 16};
      logic [59:0] p;
      wr(OFS_TOTAL, 32'h10);
      wr(OFS_CTRL, 32'h11);
      foreach (c[i]) begin
         p = with1(c[i], v[i]);
         nErr = 0;
         frame(p, p[9:0]);
         `CHK(nErr, e[i])
      end
      // Smoothed spike exceeds the limit on pixels 3..7 only, five in each of the two lines; no tap crosses lines
      nErr = 0;
      frame(with1(C_Y, BC_RGBY_MAX), 10'h3ff);
      `CHK(nErr, 10)
   endtask
   task automatic t_frame;
      wr(OFS_CTRL, 32'h13);
      rdv(OFS_FRMCNT); `CHK(rd, 32'h0)
      rdv(OFS_TIME); `CHK(rd < 32'h20, 1'h1)
      nFrm = 0;
      frame(with1(C_Y, 10'h3d9), 10'h3d9);
      frame(MID, 10'h1f4);
      repeat (40) @(posedge sys_clk);
      `CHK(nFrm, 1)
      rdv(OFS_PCT); `CHK(rd, 32'h2710)
      rdv(OFS_PIXCNT); `CHK(rd, 32'h10)
      rdv(OFS_FRMCNT); `CHK(rd, 32'h1)
      rdv(OFS_MINMAX0); `CHK(rd, 32'h03d903d9)
      wr(OFS_CTRL, 32'h10);
      nErr = 0;
      frame(with1(C_Y, 10'h3d9), 10'h3d9);
      `CHK(nErr, 0)
      rdv(OFS_PIXCNT);
      `CHK(rd, 32'h10)
      wr(OFS_CTRL, 32'h11);
   endtask
   task automatic t_thr;
      wr(OFS_SEL, 32'h3939);
      rdv(OFS_CTRL); `CHK(rd, 32'h41)
      wr(OFS_CTRL, 32'h43);
      wr(OFS_THR, 32'h4e2);
      nErr = 0;
      nFrm = 0;
      frame(MID, 10'h3e8);
      frame(MID, 10'h3e8);
      `CHK(nFrm, 0)
      wr(OFS_THR, 32'h4e1);
      frame(MID, 10'h3e8);
      repeat (40) @(posedge sys_clk);
      `CHK(nFrm, 1)
      `CHK(nErr, 6)
      rdv(OFS_PCT); `CHK(rd, 32'h4e2)
      wr(OFS_SEL, 32'h13939);
      nErr = 0;
      frame(MID, 10'h3e8);
      `CHK(nErr, 0)
   endtask
   task automatic t_narrow;
      wr(OFS_CTRL, 32'h21);
      rdv(OFS_SEL); `CHK(rd, 32'h3f3f)
      rdv(OFS_LIM0); `CHK(rd, 32'h03ac0040)
      nErr = 0;
      frame(with1(C_CB, 10'h03f), 10'h1f4);
      `CHK(nErr, 16)
      wr(OFS_LIM0, 32'h03840064);
      rdv(OFS_CTRL); `CHK(rd, 32'h41)
      wr(OFS_CTRL, 32'h11);
      rdv(OFS_SEL); `CHK(rd, 32'h13939)
      wr(OFS_CTRL, 32'h41);
      rdv(OFS_SEL); `CHK(rd, 32'h3f3f)
      rdv(OFS_LIM0); `CHK(rd, 32'h03840064)
   endtask
   task automatic t_zebra;
      wr(OFS_SEL, 32'h100);
      for (int t = 0; t < 4; t++) begin
         wr(OFS_CTRL, 32'h141 | (t << 9));
         zType = t[1:0];
         nErr = 0;
         nZeb = 0;
         nBad = 0;
         nHatch = 0;
         frame(with1(C_Y, 10'h3e8), 10'h3e8);
         `CHK(nErr, 0)
         `CHK(nZeb, 16)
         `CHK(nBad, 0)
         `CHK(nHatch > 0 && nHatch < 16, 1'h1)
      end
      wr(OFS_SEL, 32'h0);
      wr(OFS_CTRL, 32'h841);
      nMono = 0;
      frame(with1(C_R, 10'h064), 10'h1f4);
      `CHK(nMono, 0)
      wr(OFS_CTRL, 32'h41);
      nMono = 0;
      frame(with1(C_R, 10'h064), 10'h1f4);
      `CHK(nMono > 0, 1'h1)
   endtask
   // Clock enable low freezes the elapsed-time counter; only three enabled edges remain
   task automatic t_hold;
      logic [31:0] t0;
      rdv(OFS_TIME);
      t0 = rd;
      clkEn <= 1'h0;
      repeat (20) @(posedge sys_clk);
      clkEn <= 1'h1;
      rdv(OFS_TIME);
      `CHK(rd - t0, 32'h3)
   endtask
   task automatic summarize;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Whole run is under a thousand cycles; this bound only catches a hang
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'h1;
      t_reset();
      t_bcast();
      t_frame();
      t_thr();
      t_narrow();
      t_zebra();
      t_hold();
      summarize();
   end
endmodule // test_video_gamut_checker
